// file: hdl/tpe_input_cond.sv
`timescale 1ns/1ns
module tpe_input_cond
   import tpe_pkg::*;
(
   input  wire logic clock_in,
   input  wire logic rst_in,
   input  wire logic raw_in,
   input  wire logic invert_in,
   input  wire logic filter_in,
   input  wire logic enable_in,
   output logic      level_out,
   output logic      rise_out,
   output logic      fall_out
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [FILTER_LEN-1:0] hist;
      logic                  stable;
      logic                  cond;
      logic                  prev;
   } tpe_cond_t;

   tpe_cond_t cond_q;
   tpe_cond_t cond_d;

   // Filter, polarity, then edge history
   always_comb begin
      cond_d      = cond_q;
      cond_d.hist = {cond_q.hist[FILTER_LEN-2:0], raw_in};
      if (!filter_in) begin
         cond_d.stable = raw_in;
      end else if (&cond_d.hist) begin
         cond_d.stable = 1'b1;
      end else if (~|cond_d.hist) begin
         cond_d.stable = 1'b0;
      end
      cond_d.prev = cond_q.cond;
      // A channel not mapped to its pin stays quiet, so no edges leak
      cond_d.cond = enable_in & (cond_q.stable ^ invert_in);
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cond_q <= '0;
      end else begin
         cond_q <= cond_d;
      end
   end

   assign level_out = cond_q.cond;
   assign rise_out  = cond_q.cond & ~cond_q.prev;
   assign fall_out  = ~cond_q.cond & cond_q.prev;

endmodule // tpe_input_cond

// file: hdl/tpe_pkg.sv
package tpe_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int CNT_W      = 16;
   localparam int DAT_W      = 32;
   localparam int ADR_W      = 8;
   localparam int SEL_W      = 4;
   localparam int FILTER_LEN = 3;      // Samples that must agree

   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [ADR_W-1:0] OFS_CTRL    = 8'h00;
   localparam logic [ADR_W-1:0] OFS_SLAVE   = 8'h04;
   localparam logic [ADR_W-1:0] OFS_CHAN    = 8'h08;
   localparam logic [ADR_W-1:0] OFS_EVENT   = 8'h0C;
   localparam logic [ADR_W-1:0] OFS_COUNT   = 8'h10;
   localparam logic [ADR_W-1:0] OFS_RELOAD  = 8'h14;
   localparam logic [ADR_W-1:0] OFS_COMPARE = 8'h18;
   localparam logic [ADR_W-1:0] OFS_STATUS  = 8'h1C;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CTRL_RUN  = 0;
   localparam int CTRL_SHOT = 1;
   localparam int CTRL_DIR  = 2;
   localparam int CTRL_ARBE = 3;
   localparam int CTRL_CMS  = 4;       // Two bits
   localparam int SLV_SMS   = 0;       // Three bits
   localparam int SLV_TS    = 4;       // Three bits
   localparam int CH_CC1S   = 0;       // Two bits
   localparam int CH_OCM    = 2;       // Three bits
   localparam int CH_OC1BE  = 5;
   localparam int CH_FE     = 6;
   localparam int CH_CC2S   = 8;       // Two bits
   localparam int CH_P1     = 12;
   localparam int CH_P2     = 13;
   localparam int CH_F1     = 14;
   localparam int CH_F2     = 15;
   localparam int EV_UG     = 0;
   localparam int ST_REF    = 0;
   localparam int ST_OUT    = 1;
   localparam int ST_IN1    = 2;
   localparam int ST_IN2    = 3;
   localparam int ST_RUN    = 4;
   localparam int ST_DIR    = 5;

   // -----------------------------------------------------------------
   // Reset values and selector codes
   // -----------------------------------------------------------------
   localparam logic [CNT_W-1:0] RST_RELOAD  = 16'hFFFF;
   localparam logic [CNT_W-1:0] RST_COMPARE = 16'h0000;
   localparam logic [CNT_W-1:0] RST_COUNT   = 16'h0000;
   localparam logic [1:0]       CAPSEL_IN   = 2'h1;
   localparam logic [2:0]       TS_IN1      = 3'h5;
   localparam logic [2:0]       TS_IN2      = 3'h6;

   typedef enum logic [2:0] {
      SMS_OFF      = 3'b000,
      SMS_ENC_TWO  = 3'b001,
      SMS_ENC_ONE  = 3'b010,
      SMS_ENC_BOTH = 3'b011,
      SMS_RESET    = 3'b100,
      SMS_GATED    = 3'b101,
      SMS_TRIGGER  = 3'b110,
      SMS_EXTCLK   = 3'b111
   } tpe_slave_t;

   typedef enum logic [2:0] {
      OCM_FROZEN = 3'b000,
      OCM_SET    = 3'b001,
      OCM_CLEAR  = 3'b010,
      OCM_TOGGLE = 3'b011,
      OCM_LOW    = 3'b100,
      OCM_HIGH   = 3'b101,
      OCM_PWM1   = 3'b110,
      OCM_PWM2   = 3'b111
   } tpe_ocm_t;

endpackage

// file: hdl/tpe_timer.sv
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
module tpe_timer
   import tpe_pkg::*;
(
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   input  wire logic             wb_cyc_in,
   input  wire logic             wb_stb_in,
   input  wire logic             wb_we_in,
   input  wire logic [ADR_W-1:0] wb_adr_in,
   input  wire logic [SEL_W-1:0] wb_sel_in,
   input  wire logic [DAT_W-1:0] wb_dat_in,
   output logic      [DAT_W-1:0] wb_dat_out,
   output logic                  wb_ack_out,
   input  wire logic             input_one_in,
   input  wire logic             input_two_in,
   output logic                  compare_reference_out,
   output logic                  channel_output_out
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic             run;
      logic             one_shot;
      logic             dir;
      logic             arbe;
      logic [1:0]       cms;
      tpe_slave_t       sms;
      logic [2:0]       ts;
      logic [1:0]       cc1s;
      tpe_ocm_t         ocm;
      logic             oc1be;
      logic             fe;
      logic [1:0]       cc2s;
      logic             p1;
      logic             p2;
      logic             f1;
      logic             f2;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] arr_pre;
      logic [CNT_W-1:0] arr_act;
      logic [CNT_W-1:0] ccr_pre;
      logic [CNT_W-1:0] ccr_act;
      logic             ref_lvl;
      logic             chan_out;
      logic             fast_hold;
      logic             ack;
      logic [DAT_W-1:0] rdat;
   } tpe_state_t;

   localparam tpe_state_t ST_RST = '{
      sms:     SMS_OFF,
      ocm:     OCM_FROZEN,
      cnt:     RST_COUNT,
      arr_pre: RST_RELOAD,
      arr_act: RST_RELOAD,
      ccr_pre: RST_COMPARE,
      ccr_act: RST_COMPARE,
      default: '0
   };

   tpe_state_t st_q;
   tpe_state_t st_d;

   // -----------------------------------------------------------------
   // Input conditioning, one instance per channel
   // -----------------------------------------------------------------
   logic [1:0] pin_raw;
   logic [1:0] pin_inv;
   logic [1:0] pin_filt;
   logic [1:0] pin_en;
   logic [1:0] lvl;
   logic [1:0] rise;
   logic [1:0] fall;

   assign pin_raw  = {input_two_in, input_one_in};
   assign pin_inv  = {st_q.p2, st_q.p1};
   assign pin_filt = {st_q.f2, st_q.f1};
   assign pin_en   = {st_q.cc2s == CAPSEL_IN, st_q.cc1s == CAPSEL_IN};

   genvar g;
   for (g = 0; g < 2; g++) begin : g_in
      tpe_input_cond u_cond (
         .clock_in  (clock_in),
         .rst_in    (rst_in),
         .raw_in    (pin_raw[g]),
         .invert_in (pin_inv[g]),
         .filter_in (pin_filt[g]),
         .enable_in (pin_en[g]),
         .level_out (lvl[g]),
         .rise_out  (rise[g]),
         .fall_out  (fall[g])
      );
   end

   // -----------------------------------------------------------------
   // Bus helpers
   // -----------------------------------------------------------------
   function automatic logic [DAT_W-1:0] merge_bytes(
      input logic [DAT_W-1:0] old_w,
      input logic [DAT_W-1:0] new_w,
      input logic [SEL_W-1:0] sel);
      logic [DAT_W-1:0] r;
      r = old_w;
      for (int i = 0; i < SEL_W; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = new_w[8*i +: 8];
         end
      end
      return r;
   endfunction

   logic             bus_go;
   logic             bus_wr;
   logic [DAT_W-1:0] rd_img;
   logic [DAT_W-1:0] wword;

   // A request is taken once; the registered ack closes it
   assign bus_go = wb_cyc_in & wb_stb_in & ~st_q.ack;
   assign bus_wr = bus_go & wb_we_in;

   // Read image; unmapped offsets read as zero
   always_comb begin
      rd_img = '0;
      case (wb_adr_in)
         OFS_CTRL: begin
            rd_img[CTRL_RUN]           = st_q.run;
            rd_img[CTRL_SHOT]          = st_q.one_shot;
            rd_img[CTRL_DIR]           = st_q.dir;
            rd_img[CTRL_ARBE]          = st_q.arbe;
            rd_img[CTRL_CMS +: 2]      = st_q.cms;
         end
         OFS_SLAVE: begin
            rd_img[SLV_SMS +: 3]       = st_q.sms;
            rd_img[SLV_TS +: 3]        = st_q.ts;
         end
         OFS_CHAN: begin
            rd_img[CH_CC1S +: 2]       = st_q.cc1s;
            rd_img[CH_OCM +: 3]        = st_q.ocm;
            rd_img[CH_OC1BE]           = st_q.oc1be;
            rd_img[CH_FE]              = st_q.fe;
            rd_img[CH_CC2S +: 2]       = st_q.cc2s;
            rd_img[CH_P1]              = st_q.p1;
            rd_img[CH_P2]              = st_q.p2;
            rd_img[CH_F1]              = st_q.f1;
            rd_img[CH_F2]              = st_q.f2;
         end
         OFS_COUNT:   rd_img[CNT_W-1:0] = st_q.cnt;
         OFS_RELOAD:  rd_img[CNT_W-1:0] = st_q.arr_pre;
         OFS_COMPARE: rd_img[CNT_W-1:0] = st_q.ccr_pre;
         OFS_STATUS: begin
            rd_img[ST_REF]             = st_q.ref_lvl;
            rd_img[ST_OUT]             = st_q.chan_out;
            rd_img[ST_IN1]             = lvl[0];
            rd_img[ST_IN2]             = lvl[1];
            rd_img[ST_RUN]             = st_q.run;
            rd_img[ST_DIR]             = st_q.dir;
         end
         default: rd_img = '0;
      endcase
   end

   assign wword = merge_bytes(rd_img, wb_dat_in, wb_sel_in);

   // -----------------------------------------------------------------
   // Counter, slave controller, encoder and compare
   // -----------------------------------------------------------------
   logic enc_mode;
   logic trig_edge;
   logic one_only;
   logic two_only;
   logic tick;
   logic roll;
   logic force_upd;
   logic match;
   logic is_pwm;

   always_comb begin
      st_d      = st_q;
      st_d.ack  = 1'b0;
      roll      = 1'b0;
      match     = 1'b0;
      force_upd = 1'b0;
      // Software writes come first so that hardware events win
      if (bus_wr) begin
         case (wb_adr_in)
            OFS_CTRL: begin
               st_d.run  = wword[CTRL_RUN];
               st_d.one_shot = wword[CTRL_SHOT];
               st_d.dir  = wword[CTRL_DIR];
               st_d.arbe = wword[CTRL_ARBE];
               st_d.cms  = wword[CTRL_CMS +: 2];
            end
            OFS_SLAVE: begin
               st_d.sms  = tpe_slave_t'(wword[SLV_SMS +: 3]);
               st_d.ts   = wword[SLV_TS +: 3];
            end
            OFS_CHAN: begin
               st_d.cc1s  = wword[CH_CC1S +: 2];
               st_d.ocm   = tpe_ocm_t'(wword[CH_OCM +: 3]);
               st_d.oc1be = wword[CH_OC1BE];
               st_d.fe    = wword[CH_FE];
               st_d.cc2s  = wword[CH_CC2S +: 2];
               st_d.p1    = wword[CH_P1];
               st_d.p2    = wword[CH_P2];
               st_d.f1    = wword[CH_F1];
               st_d.f2    = wword[CH_F2];
            end
            OFS_EVENT: force_upd = wword[EV_UG];
            OFS_COUNT: st_d.cnt  = wword[CNT_W-1:0];
            OFS_RELOAD: begin
               st_d.arr_pre = wword[CNT_W-1:0];
               if (!st_q.arbe) begin
                  st_d.arr_act = wword[CNT_W-1:0];
               end
            end
            OFS_COMPARE: begin
               st_d.ccr_pre = wword[CNT_W-1:0];
               if (!st_q.oc1be) begin
                  st_d.ccr_act = wword[CNT_W-1:0];
               end
            end
            default: ;
         endcase
      end
      if (bus_go) begin
         st_d.ack  = 1'b1;
         st_d.rdat = rd_img;
      end
      // Encoder direction: any single-input transition, selected or not
      if (enc_mode && one_only) begin
         st_d.dir = (lvl[0] == lvl[1]);
      end else if (enc_mode && two_only) begin
         st_d.dir = lvl[0] ^ lvl[1];
      end
      // Up wraps at reload to zero, down wraps at zero to reload
      if (tick) begin
         if (!st_d.dir) begin
            if (st_d.cnt >= st_q.arr_act) begin
               st_d.cnt = '0;
               roll     = 1'b1;
            end else begin
               st_d.cnt = st_d.cnt + 16'h0001;
            end
         end else begin
            if (st_d.cnt == '0) begin
               st_d.cnt = st_q.arr_act;
               roll     = 1'b1;
            end else begin
               st_d.cnt = st_d.cnt - 16'h0001;
            end
         end
      end
      // Update event copies each preload buffer whose buffering is on (arbe, oc1be) into its active copy
      if (roll || force_upd) begin
         if (st_d.arbe) begin
            st_d.arr_act = st_d.arr_pre;
         end
         if (st_d.oc1be) begin
            st_d.ccr_act = st_d.ccr_pre;
         end
         st_d.fast_hold = 1'b0;
      end
      if (force_upd) begin
         st_d.cnt = st_d.dir ? st_d.arr_act : '0;
      end
      if (roll && st_d.one_shot) begin
         st_d.run = 1'b0;
      end
      // The trigger is last so a start is never lost to a stop
      if (trig_edge) begin
         st_d.run = 1'b1;
         if (st_d.fe && is_pwm) begin
            st_d.fast_hold = 1'b1;
         end
      end
      match = tick && (st_d.cnt == st_d.ccr_act);
      case (st_d.ocm)
         OCM_FROZEN: st_d.ref_lvl = st_q.ref_lvl;
         OCM_SET:    st_d.ref_lvl = st_q.ref_lvl | match;
         OCM_CLEAR:  st_d.ref_lvl = st_q.ref_lvl & ~match;
         OCM_TOGGLE: st_d.ref_lvl = st_q.ref_lvl ^ match;
         OCM_LOW:    st_d.ref_lvl = 1'b0;
         OCM_HIGH:   st_d.ref_lvl = 1'b1;
         OCM_PWM1:   st_d.ref_lvl = st_d.dir ?
                                    (st_d.cnt <= st_d.ccr_act) :
                                    (st_d.cnt < st_d.ccr_act);
         OCM_PWM2:   st_d.ref_lvl = st_d.dir ?
                                    (st_d.cnt > st_d.ccr_act) :
                                    (st_d.cnt >= st_d.ccr_act);
         default:    st_d.ref_lvl = st_q.ref_lvl;
      endcase
      // Fast path holds the match level until the next update event
      if (st_d.fast_hold && is_pwm) begin
         st_d.ref_lvl = (st_d.ocm == OCM_PWM2);
      end
      st_d.chan_out = st_d.ref_lvl ^ st_d.p1;
   end

   // Event decode from conditioned inputs
   always_comb begin
      enc_mode  = (st_q.sms == SMS_ENC_TWO) || (st_q.sms == SMS_ENC_ONE) ||
                  (st_q.sms == SMS_ENC_BOTH);
      trig_edge = (st_q.sms == SMS_TRIGGER) &&
                  (((st_q.ts == TS_IN2) && rise[1]) ||
                   ((st_q.ts == TS_IN1) && rise[0]));
      one_only  = (rise[0] | fall[0]) & ~(rise[1] | fall[1]);
      two_only  = (rise[1] | fall[1]) & ~(rise[0] | fall[0]);
      is_pwm    = (st_q.ocm == OCM_PWM1) || (st_q.ocm == OCM_PWM2);
      if (enc_mode) begin
         tick = st_q.run &&
                (((st_q.sms == SMS_ENC_ONE) && one_only) ||
                 ((st_q.sms == SMS_ENC_TWO) && two_only) ||
                 ((st_q.sms == SMS_ENC_BOTH) &&
                  (one_only || two_only)));
      end else begin
         tick = st_q.run;
      end
   end

   // Single register stage for all state
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // -----------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // -----------------------------------------------------------------
   assign wb_dat_out            = st_q.rdat;
   assign wb_ack_out            = st_q.ack;
   assign compare_reference_out = st_q.ref_lvl;
   assign channel_output_out    = st_q.chan_out;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   a_one_pulse_stop: assert property (
      (tick && st_q.one_shot && !st_q.dir && !bus_wr && !trig_edge &&
       st_q.cnt >= st_q.arr_act) |=> (!st_q.run && st_q.cnt == '0))
      else $error("one-pulse run did not stop at rollover");

   a_trigger_start: assert property (
      (trig_edge && !(bus_wr && wb_adr_in == OFS_CTRL)) |=> st_q.run)
      else $error("trigger edge did not start counter");

   a_trig_source: assert property (
      (st_q.sms == SMS_TRIGGER && st_q.ts == TS_IN2 && rise[1] &&
       !st_q.run && !bus_wr) |=> st_q.run ##1 (st_q.cnt != $past(st_q.cnt)))
      else $error("input two trigger did not start counting");

   a_fast_level: assert property (
      (trig_edge && st_q.fe && st_q.ocm == OCM_PWM2 && !bus_wr)
      |=> st_q.ref_lvl && st_q.chan_out == ~st_q.p1)
      else $error("fast enable did not force match level");

   a_fast_ignored: assert property (
      (!is_pwm && !bus_wr) |=> !st_q.fast_hold || $past(st_q.fast_hold))
      else $error("fast hold set outside PWM modes");

   a_pwm2_level: assert property (
      (st_q.ocm == OCM_PWM2 && !st_q.dir && !st_q.fast_hold)
      |-> st_q.ref_lvl == (st_q.cnt >= st_q.ccr_act))
      else $error("PWM mode 2 level disagrees with compare");

   a_enc_wrap: assert property (
      (enc_mode && tick && two_only && (lvl[0] ^ lvl[1]) &&
       st_q.cnt == '0 && !bus_wr)
      |=> st_q.cnt == $past(st_q.arr_act))
      else $error("encoder down count did not wrap to reload");

   a_enc_same_time: assert property (
      (enc_mode && (rise[0] | fall[0]) && (rise[1] | fall[1]) && !bus_wr)
      |=> $stable(st_q.cnt) && $stable(st_q.dir))
      else $error("simultaneous input change moved the counter");

   a_enc_dir_one: assert property (
      (enc_mode && one_only && !bus_wr)
      |=> st_q.dir == $past(lvl[0] == lvl[1]))
      else $error("direction not recomputed on input one edge");

   a_enc_no_count: assert property (
      (st_q.sms == SMS_ENC_ONE && !one_only && !bus_wr)
      |=> $stable(st_q.cnt))
      else $error("input one only mode counted another edge");

   a_ack_single: assert property (
      st_q.ack |=> !st_q.ack)
      else $error("bus ack held longer than one cycle");

   c_one_pulse: cover property (
      st_q.one_shot && trig_edge ##[1:300] (st_q.one_shot && !st_q.run));
   c_fast_path: cover property (trig_edge && st_q.fe && is_pwm);
   c_enc_both: cover property (st_q.sms == SMS_ENC_BOTH && tick);
   c_enc_wrap: cover property (enc_mode && tick && st_q.cnt == '0);

endmodule // tpe_timer

// file: tb/test_tpe_timer.sv
`timescale 1ns/1ns
module test_tpe_timer;
   import tpe_pkg::*;
   typedef struct packed {
      logic [2:0] sms; logic dn; logic [3:0] n; logic [15:0] cnt;
   } tpe_row_t;
   // Encoder rows from rest: mode, direction, steps, count
   localparam tpe_row_t ROWS [4] = '{
      '{SMS_ENC_BOTH, 1'b0, 4'h4, 16'h0004},
      '{SMS_ENC_ONE, 1'b0, 4'h4, 16'h0002},
      '{SMS_ENC_TWO, 1'b0, 4'h4, 16'h0002},
      '{SMS_ENC_BOTH, 1'b1, 4'h3, 16'h0007}}; // Wraps below zero
   logic             clock_in = 1'b0;
   logic             rst_in = 1'b1;
   logic             cyc = 1'b0;
   logic             we = 1'b0;
   logic             step = 1'b0;
   logic             dn = 1'b0;
   logic             ack, in1, in2, ref_o, chan_o;
   logic [ADR_W-1:0] adr = '0;
   logic [DAT_W-1:0] wdat = '0;
   logic [DAT_W-1:0] rdat, rd;
   int               err_total = 0;
   int               checks_done = 0;
   int               ticks = 0;
   int               chan_bad = 0;
   int               d1, w1, d2, w2;
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [DAT_W-1:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
      end
   endtask
   // Request held until ack is sampled high, data taken at that edge
   task automatic wb(input logic w, input logic [ADR_W-1:0] a,
                     input logic [DAT_W-1:0] d);
      @(posedge clock_in);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge clock_in); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
   endtask
   // Encoder steps; each is followed by 20 cycles watching the output
   task automatic move(input logic down, input int n, output int d,
                       output int w);
      d = 0;
      w = 0;
      repeat (n) begin
         @(posedge clock_in);
         step <= 1'b1;
         dn   <= down;
         @(posedge clock_in);
         step <= 1'b0;
         repeat (20) begin
            @(posedge clock_in);
            if (ref_o === 1'b1) w++;
            else if (w == 0) d++;
            // Polarity 0 everywhere, so the pin must follow the reference
            if (chan_o !== ref_o) chan_bad++;
         end
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      forever #50 clock_in = ~clock_in;
   end
   // Cut a hang short well beyond the expected run of a few hundred cycles
   always @(posedge clock_in) begin
      ticks++;
      if (ticks == 8000) begin
         err_total++;
         complete_run();
      end
   end
   tpe_timer dut (
      .clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(cyc),
      .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .input_one_in(in1), .input_two_in(in2),
      .compare_reference_out(ref_o), .channel_output_out(chan_o));
   tpe_enc_model enc (.clock_in(clock_in), .step_in(step),
      .down_in(dn), .a_out(in1), .b_out(in2));
   // Reset values, encoder table, then one-pulse with and without fast
   initial begin
      repeat (3) @(posedge clock_in);
      rst_in <= 1'b0;
      wb(1'b0, OFS_RELOAD, '0);
      chk(rd, 32'h0000FFFF);
      wb(1'b0, 8'h20, '0);
      chk(rd, '0);
      wb(1'b1, OFS_RELOAD, 32'h00000009);
      wb(1'b1, OFS_CHAN, 32'h00000101);
      foreach (ROWS[i]) begin
         wb(1'b1, OFS_CTRL, '0);
         wb(1'b1, OFS_SLAVE, DAT_W'(ROWS[i].sms));
         wb(1'b1, OFS_COUNT, '0);
         wb(1'b1, OFS_CTRL, 32'h00000001);
         move(ROWS[i].dn, ROWS[i].n, d1, w1);
         wb(1'b0, OFS_COUNT, '0);
         chk(rd, DAT_W'(ROWS[i].cnt));
         wb(1'b0, OFS_STATUS, '0);
         chk(DAT_W'(rd[ST_DIR]), DAT_W'(ROWS[i].dn));
      end
      wb(1'b1, OFS_CTRL, '0);
      // Leave input two low so that the trigger step gives a rising edge
      move(1'b1, 1, d1, w1);
      wb(1'b1, OFS_SLAVE, 32'h00000066);
      wb(1'b1, OFS_CHAN, 32'h0000011D);
      wb(1'b1, OFS_RELOAD, 32'h00000005);
      wb(1'b1, OFS_COMPARE, 32'h00000002);
      wb(1'b1, OFS_COUNT, '0);
      wb(1'b1, OFS_CTRL, 32'h00000002);
      move(1'b1, 1, d1, w1);
      chk(DAT_W'(w1), 32'h00000004);
      chk(DAT_W'(d1), 32'h00000005);
      wb(1'b0, OFS_CTRL, '0);
      chk(rd & 32'h00000001, '0);
      move(1'b0, 1, d2, w2);
      // Buffered run: new reload reaches the active copy only by update
      wb(1'b1, OFS_CHAN, 32'h0000017D);
      wb(1'b1, OFS_CTRL, 32'h0000000A);
      wb(1'b1, OFS_RELOAD, 32'h00000007);
      wb(1'b1, OFS_EVENT, 32'h00000001);
      move(1'b1, 1, d2, w2);
      chk(DAT_W'(d2 < d1), 32'h00000001);
      chk(DAT_W'(w2), 32'h00000008);
      chk(DAT_W'(chan_bad), '0);
      // Reset again after the one-pulse has stopped: registers return to their reset values
      rst_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      rst_in <= 1'b0;
      wb(1'b0, OFS_RELOAD, '0);
      chk(rd, 32'h0000FFFF);
      wb(1'b0, OFS_CHAN, '0);
      chk(rd, '0);
      complete_run();
   end
endmodule // test_tpe_timer

// file: tb/tpe_enc_model.sv
`timescale 1ns/1ns
module tpe_enc_model (
   input  wire logic clock_in,
   input  wire logic step_in,
   input  wire logic down_in,
   output logic      a_out,
   output logic      b_out
);
   logic [1:0] pos_q = 2'h0;
   // Gray order: one line moves per step, as a real shaft does
   assign a_out = pos_q[1] ^ pos_q[0];
   assign b_out = pos_q[1];
   // Step on request; no free-running phase
   always @(posedge clock_in) begin
      if (step_in) pos_q <= down_in ? pos_q - 2'h1 : pos_q + 2'h1;
   end
endmodule // tpe_enc_model
